// ===== src/nv_cmd_table.sv
// Six-entry table of soft command addresses, registered read.
// Assumes writes and reads come from the controller on one clock.
`timescale 1ns/1ps
`include "nv_host_cfg.svh"

module nv_cmd_table
(
   input  wire logic  i_sys_clk,
   input  wire logic  i_rst,
   input  wire logic  i_clk_en,
   nv_tbl_if.mem      tbl
);
   logic [`ADDR_W-1:0] entry_reg [`SEQ_LEN];

   // ========================================================================
   // Entries
   genvar g;
   generate
      for (g = 0; g < `SEQ_LEN; g++)
      begin : g_entry
         always_ff @(posedge i_sys_clk or posedge i_rst)
         begin
            if (i_rst)
               entry_reg[g] <= '0;
            else if (i_clk_en && tbl.wr_en && tbl.wr_idx == `IDX_W'(g))
               entry_reg[g] <= tbl.wr_addr;
         end
      end
   endgenerate

   // ========================================================================
   // Registered read; an index past the table reads zero
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         tbl.rd_addr <= '0;
      else if (i_clk_en)
         tbl.rd_addr <= (tbl.rd_idx < `IDX_W'(`SEQ_LEN)) ?
                        entry_reg[tbl.rd_idx] : '0;
   end
endmodule

// ===== src/nv_host_cfg.svh
// Constants of the nvSRAM host controller: widths, pin timing, waits.
// Assumes a 10 MHz system clock; every count of a printed time is derived from it.
`ifndef NV_HOST_CFG_SVH
`define NV_HOST_CFG_SVH

// ==========================================================================
// Widths and sizes
`define ADDR_W          15
`define DATA_W          8
`define CNT_W           18
`define SEQ_LEN         6
`define IDX_W           3
`define LAST_STEP       3'h5

// ==========================================================================
// Clock and printed times
`define CLK_PERIOD_NS   100
`define T_RC_NS         45
`define T_WC_NS         45
`define T_PHSB_NS       15
`define T_HHHD_NS       500
`define T_SS_US         100
`define T_RECALL_US     200
`define T_STORE_MS      8
`define T_HRECALL_MS    20

// ==========================================================================
// Cycle counts; least times round up
`define CEIL_CYC(ns)    (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RC_CYC          `CEIL_CYC(`T_RC_NS)
`define WC_CYC          `CEIL_CYC(`T_WC_NS)
`define PHSB_CYC        `CEIL_CYC(`T_PHSB_NS)
`define HHHD_CYC        `CEIL_CYC(`T_HHHD_NS)
`define SS_CYC          `CEIL_CYC(`T_SS_US * 1000)
`define RECALL_CYC      `CEIL_CYC(`T_RECALL_US * 1000)
`define STORE_CYC_DEF   `CEIL_CYC(`T_STORE_MS * 1000000)
`define HRECALL_CYC_DEF `CEIL_CYC(`T_HRECALL_MS * 1000000)
`define SETUP_CYC       3
`define ADDR_LOAD_CNT   1

`endif

// ===== src/nv_host_ctrl.sv
// Host controller for an asynchronous 32K x 8 nonvolatile SRAM.
// Assumes pin inputs synchronous to i_sys_clk and a pull-up on the
// store/busy wire; the host only ever pulls that wire low.
//
// What this block does
// - Write strobe stays high throughout every read cycle.
// - Store/busy is never pulled low during ordinary reads and writes.
// - Address changes only while chip select is high.
// - Each soft command step is a chip-select-controlled read.
// - Soft command is six consecutive reads, table order, strobe high.
// - Data from the sixth command read is discarded.
// - Each command read lasts at least 45 ns.
// - Hardware store pulls store/busy low at least 15 ns.
`timescale 1ns/1ps
`include "nv_host_cfg.svh"

module nv_host_ctrl
#(
   parameter int unsigned STORE_CYC   = `STORE_CYC_DEF,
   parameter int unsigned HRECALL_CYC = `HRECALL_CYC_DEF
)
(
   input  wire logic                i_sys_clk,
   input  wire logic                i_rst,
   input  wire logic                i_clk_en,
   input  wire logic                i_req,
   input  wire logic [1:0]          i_op,
   input  wire logic [1:0]          i_soft_kind,
   input  wire logic [`ADDR_W-1:0]  i_addr,
   input  wire logic [`DATA_W-1:0]  i_wdata,
   input  wire logic                i_tbl_we,
   input  wire logic [`IDX_W-1:0]   i_tbl_idx,
   input  wire logic [`ADDR_W-1:0]  i_tbl_addr,
   output logic                     o_ready,
   output logic                     o_done,
   output logic [`DATA_W-1:0]       o_rdata,
   output logic                     o_ce_n,
   output logic                     o_we_n,
   output logic                     o_oe_n,
   output logic [`ADDR_W-1:0]       o_addr,
   output logic [`DATA_W-1:0]       o_dq_out,
   output logic                     o_dq_oe,
   input  wire logic [`DATA_W-1:0]  i_dq_in,
   input  wire logic                i_store_busy_n,
   output logic                     o_store_busy_n_out,
   output logic                     o_store_busy_n_oe
);
   nv_host_pkg::state_t      state_reg;
   nv_host_pkg::state_t      state_next;
   nv_host_pkg::op_t         op_reg;
   nv_host_pkg::op_t         op_next;
   nv_host_pkg::soft_kind_t  kind_reg;
   logic [`CNT_W-1:0]        cnt_reg;
   logic [`CNT_W-1:0]        cnt_next;
   logic [`IDX_W-1:0]        step_reg;
   logic [`ADDR_W-1:0]       addr_reg;
   logic [`DATA_W-1:0]       wdata_reg;
   logic                     accept;
   logic                     cnt_zero;
   logic                     settle_done;
   logic                     is_read_next;
   nv_tbl_if                 tbl ();

   assign tbl.wr_en   = i_tbl_we;
   assign tbl.wr_idx  = i_tbl_idx;
   assign tbl.wr_addr = i_tbl_addr;
   assign tbl.rd_idx  = step_reg;

   nv_cmd_table u_table
   (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_clk_en  (i_clk_en),
      .tbl       (tbl.mem)
   );

   // ========================================================================
   // Sequencing
   assign cnt_zero = (cnt_reg == '0);
   // Hardware store: wait until the device lets the wire go high again;
   // the first settle cycle is skipped because the pulse may not be seen yet
   assign settle_done = i_store_busy_n &&
      (cnt_zero || (op_reg == nv_host_pkg::OP_HWSTORE &&
                    cnt_reg != `CNT_W'(STORE_CYC - 1)));
   assign op_next = accept ? nv_host_pkg::op_t'(i_op) : op_reg;
   assign is_read_next = (op_next == nv_host_pkg::OP_READ) ||
                         (op_next == nv_host_pkg::OP_SOFT);

   always_comb
   begin
      state_next = state_reg;
      accept     = 1'b0;
      unique case (state_reg)
         nv_host_pkg::ST_BOOT:
            if (cnt_zero && i_store_busy_n)
               state_next = nv_host_pkg::ST_IDLE;
         nv_host_pkg::ST_IDLE:
            if (i_req && i_store_busy_n)
            begin
               accept     = 1'b1;
               state_next = (i_op == nv_host_pkg::OP_HWSTORE) ?
                            nv_host_pkg::ST_HWPULSE : nv_host_pkg::ST_SETUP;
            end
         nv_host_pkg::ST_SETUP:
            if (cnt_zero)
               state_next = nv_host_pkg::ST_STROBE;
         nv_host_pkg::ST_STROBE:
            if (cnt_zero)
               state_next = nv_host_pkg::ST_RELEASE;
         // Six steps, then the processing wait
         nv_host_pkg::ST_RELEASE:
            if (op_reg != nv_host_pkg::OP_SOFT)
               state_next = nv_host_pkg::ST_IDLE;
            else if (step_reg != `LAST_STEP)
               state_next = nv_host_pkg::ST_SETUP;
            else
               state_next = nv_host_pkg::ST_SETTLE;
         nv_host_pkg::ST_HWPULSE:
            if (cnt_zero)
               state_next = nv_host_pkg::ST_SETTLE;
         nv_host_pkg::ST_SETTLE:
            if (settle_done)
               state_next = nv_host_pkg::ST_GUARD;
         nv_host_pkg::ST_GUARD:
            if (cnt_zero)
               state_next = nv_host_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         state_reg <= nv_host_pkg::ST_BOOT;
      else if (i_clk_en)
         state_reg <= state_next;
   end

   // ========================================================================
   // Shared down counter, reloaded on every state entry
   always_comb
   begin
      cnt_next = cnt_zero ? cnt_reg : cnt_reg - `CNT_W'(1);
      if (state_next != state_reg || state_reg == nv_host_pkg::ST_RELEASE)
      begin
         unique case (state_next)
            nv_host_pkg::ST_SETUP:
               cnt_next = `CNT_W'(`SETUP_CYC - 1);
            // Strobe width from the slow grade
            nv_host_pkg::ST_STROBE:
               cnt_next = (op_reg == nv_host_pkg::OP_WRITE) ?
                          `CNT_W'(`WC_CYC - 1) : `CNT_W'(`RC_CYC - 1);
            nv_host_pkg::ST_HWPULSE:
               cnt_next = `CNT_W'(`PHSB_CYC - 1);
            // Soft command: processing time plus the operation; hardware store: store time only
            nv_host_pkg::ST_SETTLE:
               if (op_reg == nv_host_pkg::OP_HWSTORE)
                  cnt_next = `CNT_W'(STORE_CYC - 1);
               else if (kind_reg == nv_host_pkg::KIND_STORE)
                  cnt_next = `CNT_W'(`SS_CYC + STORE_CYC - 1);
               else if (kind_reg == nv_host_pkg::KIND_RECALL)
                  cnt_next = `CNT_W'(`SS_CYC + `RECALL_CYC - 1);
               else
                  cnt_next = `CNT_W'(`SS_CYC - 1);
            // Let the device finish driving the wire high
            nv_host_pkg::ST_GUARD:
               cnt_next = `CNT_W'(`HHHD_CYC - 1);
            default:
               cnt_next = '0;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         cnt_reg <= `CNT_W'(HRECALL_CYC - 1);
      else if (i_clk_en)
         cnt_reg <= cnt_next;
   end

   // ========================================================================
   // Request capture and command step
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         op_reg    <= nv_host_pkg::OP_READ;
         kind_reg  <= nv_host_pkg::KIND_OTHER;
         addr_reg  <= '0;
         wdata_reg <= '0;
      end
      else if (i_clk_en && accept)
      begin
         op_reg    <= op_next;
         kind_reg  <= nv_host_pkg::soft_kind_t'(i_soft_kind);
         addr_reg  <= i_addr;
         wdata_reg <= i_wdata;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         step_reg <= '0;
      else if (i_clk_en)
      begin
         if (state_next == nv_host_pkg::ST_IDLE)
            step_reg <= '0;
         else if (state_reg == nv_host_pkg::ST_RELEASE &&
                  state_next == nv_host_pkg::ST_SETUP)
            step_reg <= step_reg + `IDX_W'(1);
      end
   end

   // ========================================================================
   // Memory pins
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_ce_n   <= 1'b1;
         o_we_n   <= 1'b1;
         o_oe_n   <= 1'b1;
         o_dq_oe  <= 1'b0;
         o_dq_out <= '0;
      end
      else if (i_clk_en)
      begin
         // Select and output enable clock each command step
         o_ce_n  <= (state_next != nv_host_pkg::ST_STROBE);
         o_oe_n  <= !(state_next == nv_host_pkg::ST_STROBE && is_read_next);
         // Write strobe only for write requests
         o_we_n  <= !(state_next == nv_host_pkg::ST_STROBE &&
                      op_next == nv_host_pkg::OP_WRITE);
         o_dq_oe <= (state_next == nv_host_pkg::ST_STROBE &&
                     op_next == nv_host_pkg::OP_WRITE);
         o_dq_out <= wdata_reg;
      end
   end

   // Address moves only in the setup phase, select still high
   // loading mid-setup also gives the table read its one-cycle latency
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         o_addr <= '0;
      else if (i_clk_en && state_reg == nv_host_pkg::ST_SETUP &&
               cnt_reg == `CNT_W'(`ADDR_LOAD_CNT))
         o_addr <= (op_reg == nv_host_pkg::OP_SOFT) ? tbl.rd_addr : addr_reg;
   end

   // ========================================================================
   // Store/busy wire: open drain, low only
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_store_busy_n_out <= 1'b0;
         o_store_busy_n_oe  <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_store_busy_n_out <= 1'b0;
         // Pulled only in the store pulse
         o_store_busy_n_oe  <= (state_next == nv_host_pkg::ST_HWPULSE);
      end
   end

   // ========================================================================
   // User answer
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_ready <= 1'b0;
         o_done  <= 1'b0;
         o_rdata <= '0;
      end
      else if (i_clk_en)
      begin
         o_ready <= (state_next == nv_host_pkg::ST_IDLE);
         o_done  <= (state_next == nv_host_pkg::ST_IDLE &&
                     state_reg != nv_host_pkg::ST_IDLE &&
                     state_reg != nv_host_pkg::ST_BOOT);
         // Command reads never update the read data
         if (state_reg == nv_host_pkg::ST_STROBE && cnt_zero &&
             op_reg == nv_host_pkg::OP_READ)
            o_rdata <= i_dq_in;
      end
   end

   // ========================================================================
   // Checks; the clock enable freezes time for them as well
   default clocking cb @(posedge i_sys_clk iff i_clk_en);
   endclocking
   default disable iff (i_rst);

   read_we_high_a : assert property
      (!o_oe_n |-> o_we_n && !o_ce_n)
      else $error("write strobe low during read");
   busy_idle_a : assert property
      (!o_ce_n |-> !o_store_busy_n_oe)
      else $error("store/busy pulled during access");
   addr_quiet_a : assert property
      (!$stable(o_addr) |-> o_ce_n && $past(o_ce_n))
      else $error("address changed with select low");
   boot_wait_a : assert property
      (state_reg == nv_host_pkg::ST_BOOT && !cnt_zero |=> !o_ready)
      else $error("ready before power-up recall ended");
   busy_hold_a : assert property
      (state_reg == nv_host_pkg::ST_IDLE && !i_store_busy_n |=>
       state_reg == nv_host_pkg::ST_IDLE && o_ce_n)
      else $error("access started while busy");
   soft_read_a : assert property
      (op_reg == nv_host_pkg::OP_SOFT && !o_ce_n |-> o_we_n && !o_oe_n)
      else $error("command step not a read");
   six_steps_a : assert property
      (state_reg == nv_host_pkg::ST_RELEASE &&
       op_reg == nv_host_pkg::OP_SOFT |=>
       ($past(step_reg) == `LAST_STEP) ?
          state_reg == nv_host_pkg::ST_SETTLE :
          state_reg == nv_host_pkg::ST_SETUP)
      else $error("command sequence length wrong");
   sixth_data_a : assert property
      (op_reg == nv_host_pkg::OP_SOFT |=> $stable(o_rdata))
      else $error("command read updated read data");
   strobe_width_a : assert property
      ($fell(o_ce_n) |-> ##1 o_ce_n)
      else $error("strobe width wrong");
   ss_wait_a : assert property
      (state_reg == nv_host_pkg::ST_RELEASE &&
       op_reg == nv_host_pkg::OP_SOFT && step_reg == `LAST_STEP |=>
       cnt_reg >= `CNT_W'(`SS_CYC - 1))
      else $error("soft processing wait too short");
   hw_pulse_a : assert property
      ($rose(o_store_busy_n_oe) |-> !o_store_busy_n_out ##1
       !o_store_busy_n_oe)
      else $error("store pulse width wrong");

   read_done_c  : cover property
      (op_reg == nv_host_pkg::OP_READ && o_done);
   write_done_c : cover property
      (op_reg == nv_host_pkg::OP_WRITE && o_done);
   soft_done_c  : cover property
      (op_reg == nv_host_pkg::OP_SOFT && o_done);
   hw_done_c    : cover property
      (op_reg == nv_host_pkg::OP_HWSTORE && o_done);
endmodule

// ===== src/nv_host_pkg.sv
// Types shared by the nvSRAM host controller files.
// Assumes nv_host_cfg.svh is on the include path.
`include "nv_host_cfg.svh"

package nv_host_pkg;

   // =======================================================================
   // Requests and controller states
   typedef enum logic [1:0] {
      OP_READ    = 2'h0,
      OP_WRITE   = 2'h1,
      OP_HWSTORE = 2'h2,
      OP_SOFT    = 2'h3
   } op_t;

   typedef enum logic [1:0] {
      KIND_OTHER  = 2'h0,
      KIND_STORE  = 2'h1,
      KIND_RECALL = 2'h2
   } soft_kind_t;

   typedef enum logic [2:0] {
      ST_BOOT    = 3'h0,
      ST_IDLE    = 3'h1,
      ST_SETUP   = 3'h3,
      ST_STROBE  = 3'h2,
      ST_RELEASE = 3'h6,
      ST_HWPULSE = 3'h7,
      ST_SETTLE  = 3'h5,
      ST_GUARD   = 3'h4
   } state_t;

endpackage

// ===== src/nv_tbl_if.sv
// Carrier between the controller and its command address table.
// Assumes both ends share the controller's clock.
`timescale 1ns/1ps
`include "nv_host_cfg.svh"

interface nv_tbl_if;
   logic                wr_en;
   logic [`IDX_W-1:0]   wr_idx;
   logic [`ADDR_W-1:0]  wr_addr;
   logic [`IDX_W-1:0]   rd_idx;
   logic [`ADDR_W-1:0]  rd_addr;

   modport ctrl (output wr_en, output wr_idx, output wr_addr,
                 output rd_idx, input rd_addr);
   modport mem  (input wr_en, input wr_idx, input wr_addr,
                 input rd_idx, output rd_addr);
endinterface

// ===== tb/nv_dev_model.sv
// Behavioural nonvolatile SRAM that answers the host controller.
// Assumes strobes sampled on the bench clock; i_rst stands for low supply.
`timescale 1ns/1ps

module nv_dev_model
#(
   parameter int          PWRUP_T  = 10,
   parameter int          STORE_T  = 30,
   parameter int          RECALL_T = 120,
   parameter logic [89:0] CMD_SEQ  = 90'h0
)
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   input  wire logic        i_ce_n,
   input  wire logic        i_we_n,
   input  wire logic        i_oe_n,
   input  wire logic [14:0] i_addr,
   input  wire logic [7:0]  i_dq,
   input  wire logic        i_store_busy_n,
   output logic [7:0]       o_dq,
   output logic             o_pull_low,
   output logic [7:0]       o_store_cnt,
   output logic [7:0]       o_recall_cnt
);
   logic [7:0] sram [0:32767];
   logic [7:0] nvm  [0:32767];
   logic [7:0] last_dq;
   logic       dirty;
   logic       ce_prev;
   logic [2:0] step;
   int         lock_cnt;
   logic       drive;

   // ======================================================================
   // Read data
   // clean reads only
   assign drive = !i_ce_n && !i_oe_n && i_we_n && lock_cnt == 0;
   // A floating bus shows inverted data so a stale value never passes
   assign o_dq  = drive ? sram[i_addr] : ~last_dq;

   // ======================================================================
   // Array, store and command sequence
   always @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         lock_cnt     <= PWRUP_T;
         o_pull_low   <= 1'b1;
         dirty        <= 1'b0;
         ce_prev      <= 1'b1;
         step         <= 3'h0;
         last_dq      <= 8'h00;
         o_store_cnt  <= 8'h00;
         o_recall_cnt <= 8'h00;
      end
      else
      begin
         ce_prev <= i_ce_n;
         if (drive)
            last_dq <= o_dq;
         if (lock_cnt > 0)
         begin
            lock_cnt <= lock_cnt - 1;
            if (lock_cnt == 1)
               o_pull_low <= 1'b0;
         end
         else
         begin
            if (!i_ce_n && !i_we_n)
            begin
               sram[i_addr] <= i_dq;
               dirty        <= 1'b1;
            end
            if (!i_store_busy_n && dirty)
            begin
               nvm         <= sram;
               dirty       <= 1'b0;
               lock_cnt    <= STORE_T;
               o_pull_low  <= 1'b1;
               o_store_cnt <= o_store_cnt + 8'h01;
            end
            if (!i_ce_n && ce_prev && i_we_n)
            begin
               if (i_addr != CMD_SEQ[step*15 +: 15])
                  step <= (i_addr == CMD_SEQ[14:0]) ? 3'h1 : 3'h0;
               else if (step != 3'h5)
                  step <= step + 3'h1;
               else
               begin
                  step         <= 3'h0;
                  sram         <= nvm;
                  lock_cnt     <= RECALL_T;
                  o_recall_cnt <= o_recall_cnt + 8'h01;
               end
            end
         end
      end
   end
endmodule

// ===== tb/nv_sram_access_store_recall_tb_top.sv
// Self-checking bench of the nvSRAM host controller with a device model.
// Assumes the design files and nv_dev_model are compiled before it.
`timescale 1ns/1ps

module nv_sram_access_store_recall_tb_top;
   localparam logic [89:0] CMD_SEQ = {15'h0b45, 15'h4b46, 15'h038f,
                                      15'h7c70, 15'h0e38, 15'h31c3};
   typedef struct {
      logic [7:0] rd;
      int         lo;
      int         hi;
      int         take;
   } note_t;

   logic        clk, rst, req, tbl_we, ready, done, ce_n, we_n, oe_n;
   logic        clk_en;
   logic        dq_oe, bsy_oe, bsy_out, busy_n, dev_low, ce_q;
   logic [1:0]  op, kind;
   logic [2:0]  tbl_idx;
   logic [14:0] addr, tbl_addr, o_adr, adr_q;
   logic [7:0]  wdata, rdata, dq_out, dq_in, st_cnt, rc_cnt, exp_rd;
   logic [14:0] a [8];
   logic [7:0]  d [8];
   int          cyc, err_count, n_checks;
   note_t       notes[$];
   note_t       nt;

   // Open-drain wire with pull-up: low if either party pulls
   assign busy_n = !((bsy_oe && !bsy_out) || dev_low);

   nv_host_ctrl #(.STORE_CYC(50), .HRECALL_CYC(20)) i_dut (
      .i_sys_clk(clk), .i_rst(rst), .i_clk_en(clk_en), .i_req(req),
      .i_op(op), .i_soft_kind(kind), .i_addr(addr), .i_wdata(wdata),
      .i_tbl_we(tbl_we), .i_tbl_idx(tbl_idx), .i_tbl_addr(tbl_addr),
      .o_ready(ready), .o_done(done), .o_rdata(rdata), .o_ce_n(ce_n),
      .o_we_n(we_n), .o_oe_n(oe_n), .o_addr(o_adr), .o_dq_out(dq_out),
      .o_dq_oe(dq_oe), .i_dq_in(dq_in), .i_store_busy_n(busy_n),
      .o_store_busy_n_out(bsy_out), .o_store_busy_n_oe(bsy_oe));

   nv_dev_model #(.CMD_SEQ(CMD_SEQ)) i_dev (
      .i_sys_clk(clk), .i_rst(rst), .i_ce_n(ce_n), .i_we_n(we_n),
      .i_oe_n(oe_n), .i_addr(o_adr), .i_dq(dq_out),
      .i_store_busy_n(busy_n), .o_dq(dq_in), .o_pull_low(dev_low),
      .o_store_cnt(st_cnt), .o_recall_cnt(rc_cnt));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ======================================================================
   // Checking and closing
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Pins checked every cycle; each done takes the oldest note
   always @(negedge clk)
   begin
      cyc <= cyc + 1;
      ce_q <= ce_n;
      adr_q <= o_adr;
      if (oe_n === 1'b0)
         chk(we_n, 1'b1); // write strobe high in reads
      if (ce_n === 1'b0 || ce_q === 1'b0)
         chk(o_adr, adr_q); // address held while selected
      if (ce_n === 1'b0)
         chk(bsy_oe, 1'b0); // wire left alone in access
      chk(bsy_out, 1'b0); // wire is only ever pulled low
      chk(dq_oe, !we_n); // data driven only under write strobe
      if (done === 1'b1)
      begin
         chk(notes.size() > 0, 1'b1);
         if (notes.size() > 0)
         begin
            nt = notes.pop_front();
            chk(rdata, nt.rd); // read data and held value
            chk(cyc - nt.take >= nt.lo && cyc - nt.take <= nt.hi,
                1'b1); // latency
         end
      end
      if (cyc > 7000)
      begin
         err_count++;
         finish_test();
      end
   end

   // ======================================================================
   // Driver
   task automatic run_op(input logic [1:0] o, input logic [1:0] k,
                         input logic [14:0] ad, input logic [7:0] dt,
                         input int lo, input int hi);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 5000)
      begin
         @(posedge clk);
         #10;
         n++;
      end
      req = 1'b1;
      op = o;
      kind = k;
      addr = ad;
      wdata = dt;
      @(posedge clk);
      notes.push_back('{exp_rd, lo, hi, cyc});
      #10;
      req = 1'b0;
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while ((notes.size() != 0 || ready !== 1'b1) && n < 5000)
      begin
         @(posedge clk);
         #10;
         n++;
      end
   endtask

   initial
   begin
      rst = 1'b1;
      clk_en = 1'b1;
      req = 1'b0;
      op = 2'h0;
      kind = 2'h0;
      addr = 15'h0000;
      wdata = 8'h00;
      tbl_we = 1'b0;
      tbl_idx = 3'h0;
      tbl_addr = 15'h0000;
      exp_rd = 8'h00;
      cyc = 0;
      err_count = 0;
      n_checks = 0;
      void'($urandom(14));
      repeat (20) @(posedge clk);
      #10;
      rst = 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         tbl_we = 1'b1;
         tbl_idx = 3'(i);
         tbl_addr = CMD_SEQ[i*15 +: 15];
         @(posedge clk);
         #10;
      end
      tbl_we = 1'b0;
      // Back-to-back writes, then reads of the same places
      for (int i = 0; i < 8; i++)
      begin
         a[i] = 15'(i * 32 + $urandom_range(31));
         d[i] = 8'($urandom);
         run_op(nv_host_pkg::OP_WRITE, 2'h0, a[i], d[i], 5, 5);
      end
      for (int i = 0; i < 8; i++)
      begin
         exp_rd = d[i];
         run_op(nv_host_pkg::OP_READ, 2'h0, a[i], 8'($urandom), 5, 5);
      end
      wait_idle();
      $display("Test 1 ended: writes and reads");
      run_op(nv_host_pkg::OP_HWSTORE, 2'h0, 15'h0000, 8'h00, 30, 60);
      wait_idle();
      chk(st_cnt, 8'h01); // dirty data stored
      run_op(nv_host_pkg::OP_HWSTORE, 2'h0, 15'h0000, 8'h00, 4, 15);
      // Freeze the controller mid-pulse; the pulse may only grow longer
      clk_en = 1'b0;
      repeat (4) @(posedge clk);
      #10;
      chk(bsy_oe, 1'b1); // pulse held while frozen
      clk_en = 1'b1;
      wait_idle();
      chk(st_cnt, 8'h01); // clean store skipped
      $display("Test 2 ended: hardware store");
      run_op(nv_host_pkg::OP_WRITE, 2'h0, a[0], ~d[0], 5, 5);
      run_op(nv_host_pkg::OP_SOFT, nv_host_pkg::KIND_RECALL, 15'h0000,
             8'h00, 3030, 3060);
      wait_idle();
      chk(rc_cnt, 8'h01); // six reads in table order
      exp_rd = d[0];
      run_op(nv_host_pkg::OP_READ, 2'h0, a[0], 8'h00, 5, 5);
      wait_idle();
      $display("Test 3 ended: soft recall");
      run_op(nv_host_pkg::OP_SOFT, nv_host_pkg::KIND_OTHER, 15'h0000,
             8'h00, 1030, 1040);
      run_op(nv_host_pkg::OP_SOFT, nv_host_pkg::KIND_STORE, 15'h0000,
             8'h00, 1080, 1090);
      wait_idle();
      chk(rc_cnt, 8'h03); // every full sequence recognised
      $display("Test 4 ended: other soft kinds");
      finish_test();
   end
endmodule
